//--- quad_timer_pkg.sv
package quad_timer_pkg;

   // Configuration header offsets (byte addresses).
   localparam logic [7:0] CFG_IDENT    = 8'h00;
   localparam logic [7:0] CFG_CMD_STAT = 8'h04;
   localparam logic [7:0] CFG_CLASS    = 8'h08;
   localparam logic [7:0] CFG_HDR      = 8'h0c;
   localparam logic [7:0] CFG_BAR_CTL  = 8'h10;
   localparam logic [7:0] CFG_BAR_NVR  = 8'h14;
   localparam logic [7:0] CFG_BAR_TMR  = 8'h18;
   localparam logic [7:0] CFG_SUBSYS   = 8'h2c;
   localparam logic [7:0] CFG_INT      = 8'h3c;

   // Timer window offsets (byte addresses inside the window).
   localparam logic [5:0] OFS_CTRL   = 6'h00;
   localparam logic [5:0] OFS_LATCH  = 6'h04;
   localparam logic [5:0] OFS_LOAD12 = 6'h10;
   localparam logic [5:0] OFS_LOAD3  = 6'h14;
   localparam logic [5:0] OFS_LOAD4  = 6'h18;
   localparam logic [5:0] OFS_CUR12  = 6'h20;
   localparam logic [5:0] OFS_CUR3   = 6'h24;
   localparam logic [5:0] OFS_CUR4   = 6'h28;
   localparam logic [5:0] OFS_CLR1   = 6'h30;
   localparam logic [5:0] OFS_CLR2   = 6'h34;
   localparam logic [5:0] OFS_CLR3   = 6'h38;
   localparam logic [5:0] OFS_CLR4   = 6'h3c;

   // Per-timer byte lane of the control and cause register.
   localparam int LANE_W    = 8;
   localparam int CAUSE_BIT = 0;
   localparam int RUN_BIT   = 1;
   localparam int IRQEN_BIT = 2;
   localparam int SEL_LSB   = 3;
   localparam int LATCH_ALL_BIT = 0;
   localparam logic [31:0] CTRL_RESET  = 32'h00000000;
   localparam logic [31:0] LATCH_RESET = 32'h00000000;
   localparam logic [31:0] LOAD_RESET  = 32'h00000000;

   // Window sizes as address bits, command and status bit positions.
   localparam int TMR_WIN_BITS = 6;
   localparam int NVR_WIN_BITS = 15;
   localparam int CMD_MEM_BIT  = 1;
   localparam int STAT_INT_BIT = 19;
   localparam logic [7:0] INT_PIN_A = 8'h01;
   localparam logic [7:0] HDR_TYPE  = 8'h00;

   // Timer clock rates: 2 MHz, 1 MHz, 500 kHz, 250 kHz by select code.
   localparam int CLK_PERIOD_NS = 10;
   localparam int RATE0_NS = 500;
   localparam int RATE1_NS = 1000;
   localparam int RATE2_NS = 2000;
   localparam int RATE3_NS = 4000;
   localparam int DIV_W = 9;
   localparam logic [DIV_W-1:0] RATE0_CYC = DIV_W'(RATE0_NS / CLK_PERIOD_NS);
   localparam logic [DIV_W-1:0] RATE1_CYC = DIV_W'(RATE1_NS / CLK_PERIOD_NS);
   localparam logic [DIV_W-1:0] RATE2_CYC = DIV_W'(RATE2_NS / CLK_PERIOD_NS);
   localparam logic [DIV_W-1:0] RATE3_CYC = DIV_W'(RATE3_NS / CLK_PERIOD_NS);

endpackage

//--- timer_rate_gen.sv
module timer_rate_gen (
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic [1:0] sel,
   output logic            tick
);

   typedef struct packed {
      logic [quad_timer_pkg::DIV_W-1:0] cnt;
      logic                             tick;
   } gen_t;

   gen_t s;
   gen_t next_s;
   logic [quad_timer_pkg::DIV_W-1:0] limit;

   always_comb begin
      case (sel)
         2'h0:    limit = quad_timer_pkg::RATE0_CYC;
         2'h1:    limit = quad_timer_pkg::RATE1_CYC;
         2'h2:    limit = quad_timer_pkg::RATE2_CYC;
         default: limit = quad_timer_pkg::RATE3_CYC;
      endcase
   end

   // A change of rate takes effect at once; a count already past the new
   // limit wraps on the next cycle rather than running on to overflow.
   always_comb begin
      next_s = s;
      next_s.tick = 1'b0;
      if (s.cnt >= limit - 1'b1) begin
         next_s.cnt = '0;
         next_s.tick = 1'b1;
      end else begin
         next_s.cnt = s.cnt + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign tick = s.tick;

endmodule

//--- timer_channel.sv
module timer_channel #(
   parameter int W = 16
) (
   input  wire logic         clk,
   input  wire logic         resetn,
   input  wire logic         tick,
   input  wire logic         run,
   input  wire logic         loadReq,
   input  wire logic [W-1:0] loadValue,
   output logic [W-1:0]      count,
   output logic              expired
);

   typedef struct packed {
      logic         pend;
      logic [W-1:0] count;
      logic         expired;
   } chan_t;

   chan_t s;
   chan_t next_s;

   always_comb begin
      next_s = s;
      next_s.expired = 1'b0;
      if (tick) begin
         if (s.pend) begin
            next_s.count = loadValue;
            next_s.pend = 1'b0;
         end else if (run) begin
            if (s.count == '0) begin
               next_s.count = loadValue;
               next_s.expired = 1'b1;
            end else begin
               next_s.count = s.count - 1'b1;
            end
         end
      end
      // A write landing on the tick itself waits for the following tick.
      if (loadReq) begin
         next_s.pend = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign count = s.count;
   assign expired = s.expired;

endmodule

//--- quad_interval_timers.sv
module quad_interval_timers #(
   parameter logic [15:0] VENDOR_CODE     = 16'h1234, // arbitrary value
   parameter logic [15:0] DEVICE_CODE     = 16'h0001, // arbitrary value
   parameter logic [15:0] SUB_VENDOR_CODE = 16'h1234, // arbitrary value
   parameter logic [15:0] SUB_DEVICE_CODE = 16'h0002, // arbitrary value
   parameter logic [31:0] CLASS_REV_CODE  = 32'h11800000,
   parameter int          CTL_WIN_BITS    = 12
) (
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic        cfgSel,
   input  wire logic        memSel,
   input  wire logic        wrEn,
   input  wire logic        rdEn,
   input  wire logic [31:0] addr,
   input  wire logic [3:0]  byteEn,
   input  wire logic [31:0] wdata,
   output logic [31:0]      rdata,
   output logic             ack,
   output logic             claim,
   output logic             intAOut,
   output logic             intAOe
);

   localparam int NT = 4;
   // The lane width is fixed here because the timer loop below needs it.
   localparam int LANE_W = quad_timer_pkg::LANE_W;

   typedef struct packed {
      logic [31:0]         ctrl;
      logic [31:0]         latchMode;
      logic [31:0]         load12;
      logic [31:0]         load3;
      logic [31:0]         load4;
      logic [NT-1:0][31:0] latched;
      logic                memEn;
      logic [31:0]         barCtl;
      logic [31:0]         barNvr;
      logic [31:0]         barTmr;
      logic [7:0]          intLine;
      logic [NT-1:0]       loadPulse;
      logic [31:0]         rdata;
      logic                ack;
      logic                claim;
      logic                intA;
   } regs_t;

   regs_t s;
   regs_t next_s;

   logic [NT-1:0][31:0] live;
   logic [NT-1:0][31:0] loadVal;
   logic [NT-1:0]       tick;
   logic [NT-1:0]       expired;

   // Byte-enable merge of a write into a stored word.
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  be);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[8*b +: 8] = nw[8*b +: 8];
         end
      end
      return r;
   endfunction

   // Base register with the window size bits forced to zero.
   function automatic logic [31:0] bar_mask(input logic [31:0] v,
                                            input int          bits);
      logic [31:0] r;
      r = v;
      for (int b = 0; b < 32; b++) begin
         if (b < bits) begin
            r[b] = 1'b0;
         end
      end
      return r;
   endfunction

   assign loadVal[0] = {16'h0000, s.load12[15:0]};
   assign loadVal[1] = {16'h0000, s.load12[31:16]};
   assign loadVal[2] = s.load3;
   assign loadVal[3] = s.load4;

   generate
      for (genvar i = 0; i < NT; i++) begin : g_timer
         localparam int W = (i < 2) ? 16 : 32;
         logic [W-1:0] cnt;

         timer_rate_gen u_rate (
            .clk    (clk),
            .resetn (resetn),
            .sel    (s.ctrl[LANE_W*i + quad_timer_pkg::SEL_LSB +: 2]),
            .tick   (tick[i])
         );

         timer_channel #(
            .W (W)
         ) u_chan (
            .clk       (clk),
            .resetn    (resetn),
            .tick      (tick[i]),
            .run       (s.ctrl[LANE_W*i + quad_timer_pkg::RUN_BIT]),
            .loadReq   (s.loadPulse[i]),
            .loadValue (loadVal[i][W-1:0]),
            .count     (cnt),
            .expired   (expired[i])
         );

         assign live[i] = 32'(cnt);
      end
   endgenerate

   logic        cfgReq;
   logic        memReq;
   logic [5:0]  ofs;
   logic [31:0] rd;
   logic        hit;
   logic        latchAll;

   always_comb begin
      next_s = s;
      next_s.ack = 1'b0;
      next_s.claim = 1'b0;
      next_s.rdata = 32'h00000000;
      next_s.loadPulse = '0;
      rd = 32'h00000000;
      hit = 1'b0;
      ofs = addr[5:0];
      latchAll = s.latchMode[quad_timer_pkg::LATCH_ALL_BIT];
      cfgReq = cfgSel && (rdEn || wrEn);
      // The base is aligned to the window size, so only the upper address
      // bits are compared and the low six select the register.
      memReq = !cfgSel && memSel && (rdEn || wrEn) && s.memEn &&
               (addr[31:quad_timer_pkg::TMR_WIN_BITS] ==
                s.barTmr[31:quad_timer_pkg::TMR_WIN_BITS]);

      if (cfgReq) begin
         hit = 1'b1;
         case (addr[7:0])
            quad_timer_pkg::CFG_IDENT: begin
               rd = {DEVICE_CODE, VENDOR_CODE};
            end
            quad_timer_pkg::CFG_CMD_STAT: begin
               // Only memory decoding is kept; the other command bits read
               // as zero because this function never masters the bus.
               rd = 32'h00000000;
               rd[quad_timer_pkg::CMD_MEM_BIT] = s.memEn;
               rd[quad_timer_pkg::STAT_INT_BIT] = s.intA;
               if (wrEn && byteEn[0]) begin
                  next_s.memEn = wdata[quad_timer_pkg::CMD_MEM_BIT];
               end
            end
            quad_timer_pkg::CFG_CLASS: begin
               rd = CLASS_REV_CODE;
            end
            quad_timer_pkg::CFG_HDR: begin
               rd = {8'h00, quad_timer_pkg::HDR_TYPE, 16'h0000};
            end
            quad_timer_pkg::CFG_BAR_CTL: begin
               rd = bar_mask(s.barCtl, CTL_WIN_BITS);
               if (wrEn) begin
                  next_s.barCtl = merge(s.barCtl, wdata, byteEn);
               end
            end
            quad_timer_pkg::CFG_BAR_NVR: begin
               rd = bar_mask(s.barNvr, quad_timer_pkg::NVR_WIN_BITS);
               if (wrEn) begin
                  next_s.barNvr = merge(s.barNvr, wdata, byteEn);
               end
            end
            quad_timer_pkg::CFG_BAR_TMR: begin
               rd = bar_mask(s.barTmr, quad_timer_pkg::TMR_WIN_BITS);
               if (wrEn) begin
                  next_s.barTmr = merge(s.barTmr, wdata, byteEn);
               end
            end
            quad_timer_pkg::CFG_SUBSYS: begin
               rd = {SUB_DEVICE_CODE, SUB_VENDOR_CODE};
            end
            quad_timer_pkg::CFG_INT: begin
               // Only the line byte is writable; the pin byte always reports
               // the first interrupt line.
               rd = {16'h0000, quad_timer_pkg::INT_PIN_A, s.intLine};
               if (wrEn && byteEn[0]) begin
                  next_s.intLine = wdata[7:0];
               end
            end
            default: begin
               rd = 32'h00000000;
            end
         endcase
      end else if (memReq) begin
         hit = 1'b1;
         case (ofs)
            quad_timer_pkg::OFS_CTRL: begin
               rd = s.ctrl;
               if (wrEn) begin
                  next_s.ctrl = merge(s.ctrl, wdata, byteEn);
               end
            end
            quad_timer_pkg::OFS_LATCH: begin
               rd = s.latchMode;
               if (wrEn) begin
                  next_s.latchMode = merge(s.latchMode, wdata, byteEn);
               end
            end
            quad_timer_pkg::OFS_LOAD12: begin
               // A load is only marked here; the channel applies it on its
               // own timer clock, so a count never jumps between ticks.
               rd = s.load12;
               if (wrEn) begin
                  next_s.load12 = merge(s.load12, wdata, byteEn);
                  next_s.loadPulse[0] = byteEn[0] || byteEn[1];
                  next_s.loadPulse[1] = byteEn[2] || byteEn[3];
               end
            end
            quad_timer_pkg::OFS_LOAD3: begin
               rd = s.load3;
               if (wrEn) begin
                  next_s.load3 = merge(s.load3, wdata, byteEn);
                  next_s.loadPulse[2] = |byteEn;
               end
            end
            quad_timer_pkg::OFS_LOAD4: begin
               rd = s.load4;
               if (wrEn) begin
                  next_s.load4 = merge(s.load4, wdata, byteEn);
                  next_s.loadPulse[3] = |byteEn;
               end
            end
            quad_timer_pkg::OFS_CUR12: begin
               // The live count is returned and captured in one step.
               rd = {live[1][15:0], live[0][15:0]};
               if (rdEn) begin
                  next_s.latched[0] = live[0];
                  next_s.latched[1] = live[1];
                  if (latchAll) begin
                     next_s.latched[2] = live[2];
                     next_s.latched[3] = live[3];
                  end
               end
            end
            quad_timer_pkg::OFS_CUR3: begin
               // In latch-all mode the snapshot from the low-pair read must
               // survive this read, so the stored copy is returned.
               rd = latchAll ? s.latched[2] : live[2];
               if (rdEn && !latchAll) begin
                  next_s.latched[2] = live[2];
               end
            end
            quad_timer_pkg::OFS_CUR4: begin
               rd = latchAll ? s.latched[3] : live[3];
               if (rdEn && !latchAll) begin
                  next_s.latched[3] = live[3];
               end
            end
            quad_timer_pkg::OFS_CLR1, quad_timer_pkg::OFS_CLR2,
            quad_timer_pkg::OFS_CLR3, quad_timer_pkg::OFS_CLR4: begin
               // Write-only ports; the data written does not matter.
               rd = 32'h00000000;
               if (wrEn) begin
                  next_s.ctrl[LANE_W*32'(ofs[3:2]) +
                              quad_timer_pkg::CAUSE_BIT] = 1'b0;
               end
            end
            default: begin
               rd = 32'h00000000;
            end
         endcase
      end

      // Timeouts are applied after any software clear, so an expiry in the
      // same cycle as a clear keeps the flag set and no event is lost.
      for (int i = 0; i < NT; i++) begin
         if (expired[i]) begin
            next_s.ctrl[LANE_W*i + quad_timer_pkg::CAUSE_BIT] = 1'b1;
         end
      end

      // The pin follows the next register values, so a clear or an enable
      // reaches it in the same cycle as the control register itself.
      next_s.intA = 1'b0;
      for (int i = 0; i < NT; i++) begin
         if (next_s.ctrl[LANE_W*i + quad_timer_pkg::CAUSE_BIT] &&
             next_s.ctrl[LANE_W*i + quad_timer_pkg::IRQEN_BIT]) begin
            next_s.intA = 1'b1;
         end
      end

      if (hit) begin
         next_s.ack = 1'b1;
         next_s.claim = 1'b1;
         next_s.rdata = rdEn ? rd : 32'h00000000;
      end else if (memSel && (rdEn || wrEn)) begin
         // Unclaimed memory cycles are acknowledged so the host never hangs.
         next_s.ack = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s <= '0;
         s.ctrl <= quad_timer_pkg::CTRL_RESET;
         s.latchMode <= quad_timer_pkg::LATCH_RESET;
         s.load12 <= quad_timer_pkg::LOAD_RESET;
         s.load3 <= quad_timer_pkg::LOAD_RESET;
         s.load4 <= quad_timer_pkg::LOAD_RESET;
      end else begin
         s <= next_s;
      end
   end

   assign rdata = s.rdata;
   assign ack = s.ack;
   assign claim = s.claim;
   // The interrupt pin is open drain: it is only ever pulled low.
   assign intAOut = 1'b0;
   assign intAOe = s.intA;

endmodule

//--- quad_timer_checker.sv
module quad_timer_checker #(
   // Identity defaults are arbitrary values.
   parameter logic [15:0] VENDOR_CODE     = 16'h1234,
   parameter logic [15:0] DEVICE_CODE     = 16'h0001,
   parameter logic [15:0] SUB_VENDOR_CODE = 16'h1234,
   parameter logic [15:0] SUB_DEVICE_CODE = 16'h0002
) (
   input wire logic        clk,
   input wire logic        resetn,
   input wire logic        cfgSel,
   input wire logic        memSel,
   input wire logic        wrEn,
   input wire logic        rdEn,
   input wire logic [31:0] addr,
   input wire logic [3:0]  byteEn,
   input wire logic [31:0] wdata,
   input wire logic [31:0] rdata,
   input wire logic        ack,
   input wire logic        claim,
   input wire logic        intAOut,
   input wire logic        intAOe
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   sequence s_req;
      (cfgSel || memSel) && (rdEn || wrEn);
   endsequence
   sequence s_cfgRd(logic [7:0] ofs);
      cfgSel && rdEn && !wrEn && addr[7:0] == ofs ##1 ack;
   endsequence

   property p_ackLat;
      s_req |=> ack;
   endproperty
   a_ackLat: assert property (p_ackLat)
      else $error("access not answered one cycle later");
   property p_ackCause;
      ack |-> $past((cfgSel || memSel) && (rdEn || wrEn));
   endproperty
   a_ackCause: assert property (p_ackCause)
      else $error("answer without a request");
   property p_claim;
      claim |-> ack;
   endproperty
   a_claim: assert property (p_claim)
      else $error("claim outside an answer");
   property p_cfgClaim;
      cfgSel && (rdEn || wrEn) |=> claim;
   endproperty
   a_cfgClaim: assert property (p_cfgClaim)
      else $error("configuration access not claimed");
   property p_idle;
      !ack |-> rdata == 32'h0;
   endproperty
   a_idle: assert property (p_idle)
      else $error("read data outside an answer");
   property p_pinData;
      intAOut == 1'b0;
   endproperty
   a_pinData: assert property (p_pinData)
      else $error("interrupt data not low");
   property p_irqFall;
      $fell(intAOe) |-> $past(memSel && wrEn);
   endproperty
   a_irqFall: assert property (p_irqFall)
      else $error("interrupt dropped without a write");
   property p_ident;
      s_cfgRd(8'h00) |-> rdata == {DEVICE_CODE, VENDOR_CODE};
   endproperty
   a_ident: assert property (p_ident)
      else $error("wrong identification word");
   property p_subsys;
      s_cfgRd(8'h2c) |-> rdata == {SUB_DEVICE_CODE, SUB_VENDOR_CODE};
   endproperty
   a_subsys: assert property (p_subsys)
      else $error("wrong subsystem word");
endmodule

bind quad_interval_timers quad_timer_checker #(
   .VENDOR_CODE(VENDOR_CODE), .DEVICE_CODE(DEVICE_CODE),
   .SUB_VENDOR_CODE(SUB_VENDOR_CODE), .SUB_DEVICE_CODE(SUB_DEVICE_CODE)
) quad_timer_checker_i (
   .clk(clk), .resetn(resetn), .cfgSel(cfgSel), .memSel(memSel),
   .wrEn(wrEn), .rdEn(rdEn), .addr(addr), .byteEn(byteEn),
   .wdata(wdata), .rdata(rdata), .ack(ack), .claim(claim),
   .intAOut(intAOut), .intAOe(intAOe));

//--- pci_host_model.sv
module pci_host_model (
   input  wire logic        clk,
   output logic             cfgSel,
   output logic             memSel,
   output logic             wrEn,
   output logic             rdEn,
   output logic [31:0]      addr,
   output logic [3:0]       byteEn,
   output logic [31:0]      wdata,
   input  wire logic [31:0] rdata,
   input  wire logic        ack,
   input  wire logic        claim
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      {cfgSel, memSel, wrEn, rdEn} = 4'h0;
      addr = 32'h0;
      byteEn = 4'h0;
      wdata = 32'h0;
   end
   // A request is a one-cycle pulse; released lines show inverted values
   // so that a stale address or data word can never look valid.
   task automatic access(input logic c, input logic w,
                         input logic [31:0] a, input logic [3:0] be,
                         input logic [31:0] d, output logic [31:0] q,
                         output logic hit, output logic ok);
      @(posedge clk);
      cfgSel <= c;
      memSel <= !c;
      wrEn <= w;
      rdEn <= !w;
      addr <= a;
      byteEn <= be;
      wdata <= d;
      @(posedge clk);
      {cfgSel, memSel, wrEn, rdEn} <= 4'h0;
      addr <= ~a;
      byteEn <= ~be;
      wdata <= ~d;
      ok = 1'b0;
      q = 32'h0;
      hit = 1'b0;
      for (int n = 0; n < 4 && !ok; n++) begin
         @(posedge clk);
         if (ack === 1'b1) begin
            ok = 1'b1;
            q = rdata;
            hit = claim;
         end
      end
   endtask
endmodule

//--- tb_top.sv
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   // Identity codes below are arbitrary values.
   localparam logic [15:0] VEND  = 16'h5a5a;
   localparam logic [15:0] DEV   = 16'h0c01;
   localparam logic [15:0] SVEND = 16'h5a5b;
   localparam logic [15:0] SDEV  = 16'h0c02;
   localparam logic [31:0] BASE  = 32'h00002000;
   logic        clk, resetn, cfgSel, memSel, wrEn, rdEn;
   logic        ack, claim, intAOut, intAOe, hit, ok;
   logic [31:0] addr, wdata, rdata, q, a, b;
   logic [31:0] ctrlM = 32'h0;
   logic [3:0]  byteEn;
   int          n_errors = 0;
   int          checks = 0;
   int          cyc = 0;
   int          t0;

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) cyc <= cyc + 1;

   quad_interval_timers #(.VENDOR_CODE(VEND), .DEVICE_CODE(DEV),
      .SUB_VENDOR_CODE(SVEND), .SUB_DEVICE_CODE(SDEV))
   quad_interval_timers_i (.clk(clk), .resetn(resetn), .cfgSel(cfgSel),
      .memSel(memSel), .wrEn(wrEn), .rdEn(rdEn), .addr(addr),
      .byteEn(byteEn), .wdata(wdata), .rdata(rdata), .ack(ack),
      .claim(claim), .intAOut(intAOut), .intAOe(intAOe));
   pci_host_model pci_host_model_i (.clk(clk), .cfgSel(cfgSel),
      .memSel(memSel), .wrEn(wrEn), .rdEn(rdEn), .addr(addr),
      .byteEn(byteEn), .wdata(wdata), .rdata(rdata), .ack(ack),
      .claim(claim));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic acc(input logic c, input logic w, input logic [7:0] o,
                      input logic [31:0] d, input logic [3:0] be);
      pci_host_model_i.access(c, w, c ? {24'h0, o} : BASE + {24'h0, o},
                              be, d, q, hit, ok);
      check({31'h0, ok}, 32'h1);
   endtask
   task automatic mw(input logic [7:0] o, input logic [31:0] d,
                     input logic [3:0] be);
      acc(1'b0, 1'b1, o, d, be);
   endtask
   task automatic mc(input logic [7:0] o, input logic [31:0] e);
      acc(1'b0, 1'b0, o, 32'h0, 4'hf);
      check(q, e);
   endtask
   task automatic cc(input logic [7:0] o, input logic [31:0] e);
      acc(1'b1, 1'b0, o, 32'h0, 4'hf);
      check(q, e);
   endtask
   // The model keeps every lane that software wrote, cause flags aside.
   task automatic wrc(input logic [31:0] d, input logic [3:0] be);
      for (int b = 0; b < 4; b++)
         if (be[b]) ctrlM[8*b +: 8] = d[8*b +: 8];
      mw(8'h00, d, be);
   endtask
   task automatic waitIrq();
      for (int n = 0; n < 3000 && intAOe !== 1'b1; n++) @(posedge clk);
      check({31'h0, intAOe}, 32'h1);
   endtask
   task automatic rd(input logic [7:0] o);
      acc(1'b0, 1'b0, o, 32'h0, 4'hf);
   endtask
   // Reads 126 to 135 cycles apart must see two or three ticks at 2MHz.
   task automatic dn(input logic [31:0] p);
      check({31'h0, p - q == 32'h2 || p - q == 32'h3}, 32'h1);
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   initial begin
      #(300000);
      n_errors++;
      conclude();
   end

   initial begin
      resetn = 1'b0;
      void'($urandom(32'hf3b378cd));
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      cc(8'h18, 32'h0);
      cc(8'h00, {DEV, VEND});
      cc(8'h2c, {SDEV, SVEND});
      mc(8'h00, 32'h0);
      check({31'h0, hit}, 32'h0);
      acc(1'b1, 1'b1, 8'h18, 32'hffffffff, 4'hf);
      cc(8'h18, 32'hffffffc0);
      acc(1'b1, 1'b1, 8'h18, BASE, 4'hf);
      acc(1'b1, 1'b1, 8'h04, 32'hffffffff, 4'hf);
      cc(8'h04, 32'h2);
      mc(8'h00, 32'h0);
      mc(8'h04, 32'h0);
      $display("config test done");
      // Run and cause bits stay clear so no timer moves under the check.
      for (int i = 0; i < 6; i++) begin
         wrc($urandom & 32'hfcfcfcfc, 4'($urandom));
         mc(8'h00, ctrlM);
      end
      a = $urandom & 32'hfffffffe;
      mw(8'h04, a, 4'hf);
      mc(8'h04, a);
      mw(8'h04, 32'h0, 4'hf);
      wrc(32'h0, 4'hf);
      $display("register test done");
      a = $urandom;
      mw(8'h10, a, 4'hf);
      mw(8'h14, ~a, 4'hf);
      mw(8'h18, {a[15:0], a[31:16]}, 4'hf);
      repeat (60) @(posedge clk);
      mc(8'h20, a);
      mc(8'h24, ~a);
      mc(8'h28, {a[15:0], a[31:16]});
      mc(8'h10, a);
      mw(8'h20, ~a, 4'hf);
      repeat (200) @(posedge clk);
      mc(8'h20, a);
      mc(8'h08, 32'h0);
      check({31'h0, hit}, 32'h1);
      mc(8'h40, 32'h0);
      check({31'h0, hit}, 32'h0);
      $display("load test done");
      mw(8'h10, 32'h3, 4'h3);
      wrc(32'h2, 4'h1);
      repeat (300) @(posedge clk);
      check({31'h0, intAOe}, 32'h0);
      mc(8'h00, 32'h3);
      wrc(32'h7, 4'h1);
      @(posedge clk);
      check({31'h0, intAOe}, 32'h1);
      cc(8'h04, 32'h00080002);
      wrc(32'h0, 4'h1);
      @(posedge clk);
      check({31'h0, intAOe}, 32'h0);
      $display("irq enable test done");
      // Timer s+1 runs with select code s, so each code meets a timer.
      for (int s = 0; s < 4; s++) begin
         if (s < 2) mw(8'h10, 32'h3 << (16*s), s ? 4'hc : 4'h3);
         else mw(8'(8'h14 + 4*(s-2)), 32'h3, 4'hf);
         wrc((32'h6 | (s << 3)) << (8*s), 4'(1 << s));
         waitIrq();
         t0 = cyc;
         mc(8'h00, ctrlM | (32'h1 << (8*s)));
         if (s % 2 == 1) wrc(ctrlM, 4'(1 << s));
         else mw(8'(8'h30 + 4*s), $urandom, 4'hf);
         @(posedge clk);
         check({31'h0, intAOe}, 32'h0);
         waitIrq();
         check(cyc - t0, 200 << s);
         wrc(32'h0, 4'(1 << s));
         @(posedge clk);
         check({31'h0, intAOe}, 32'h0);
      end
      $display("period test done");
      mw(8'h14, 32'hf0000000, 4'hf);
      mw(8'h18, 32'hf0000000, 4'hf);
      wrc(32'h02020000, 4'hc);
      repeat (60) @(posedge clk);
      rd(8'h24);
      a = q;
      check({31'h0, 32'hf0000000 - a < 32'h3}, 32'h1);
      rd(8'h28);
      b = q;
      check({31'h0, 32'hf0000000 - b < 32'h3}, 32'h1);
      repeat (120) @(posedge clk);
      rd(8'h24);
      dn(a);
      rd(8'h28);
      dn(b);
      mw(8'h04, 32'h1, 4'hf);
      mc(8'h04, 32'h1);
      rd(8'h20);
      rd(8'h24);
      a = q;
      rd(8'h28);
      b = q;
      repeat (120) @(posedge clk);
      mc(8'h24, a);
      mc(8'h28, b);
      rd(8'h20);
      rd(8'h24);
      dn(a);
      rd(8'h28);
      dn(b);
      wrc(32'h0, 4'hf);
      $display("latch test done");
      resetn <= 1'b0;
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      ctrlM = 32'h0;
      cc(8'h18, 32'h0);
      acc(1'b1, 1'b1, 8'h18, BASE, 4'hf);
      acc(1'b1, 1'b1, 8'h04, 32'h2, 4'hf);
      mc(8'h00, 32'h0);
      mc(8'h04, 32'h0);
      $display("reset test done");
      conclude();
   end
endmodule
